// >>> rtl/twf_core.v
// Two-wire bus framing engine: master byte sequencer and slave responder.
`timescale 1ns/1ps
`include "twf_defs.vh"
module twf_core (
    input wire sys_clk,
    input wire resetn,
    input wire scl_in,
    output reg scl_out,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire cmd_valid,
    input wire [1:0] cmd_code,
    input wire [7:0] cmd_data,
    input wire cmd_nack,
    output reg cmd_ready,
    output reg m_done,
    output reg m_err,
    output reg m_ack,
    output reg [7:0] m_rd_data,
    output reg bus_busy,
    output reg start_seen,
    output reg stop_seen,
    input wire sl_en,
    input wire [6:0] sl_addr,
    input wire sl_gc_en,
    input wire sl_ready,
    input wire [7:0] sl_tx_data,
    input wire sl_tx_valid,
    output reg sl_addr_hit,
    output reg sl_gc_hit,
    output reg sl_rw,
    output reg sl_rx_valid,
    output reg [7:0] sl_rx_data,
    output reg sl_tx_take,
    output reg sl_nack_seen
);
    localparam [6:0] M_IDLE = 7'h01;
    localparam [6:0] M_STA = 7'h02;
    localparam [6:0] M_LOW = 7'h04;
    localparam [6:0] M_HIGH = 7'h08;
    localparam [6:0] M_FIN = 7'h10;
    localparam [6:0] M_STP = 7'h20;
    localparam [6:0] M_WAIT = 7'h40;
    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_ADDR = 4'h2;
    localparam [3:0] S_RX = 4'h4;
    localparam [3:0] S_TX = 4'h8;
    localparam integer HALF_CYC = `TWF_HALF_CYC;
    localparam [`TWF_CNT_W-1:0] HALF = HALF_CYC[`TWF_CNT_W-1:0];

    reg rst_meta;
    reg rst_n;
    wire [1:0] line;
    wire scl_hi;
    wire sda_hi;
    wire start_p;
    wire stop_p;
    wire scl_rise;
    wire scl_fall;
    wire busy;

    reg [6:0] m_state;
    reg [1:0] m_step;
    reg [`TWF_CNT_W-1:0] m_cnt;
    reg [8:0] m_shift;
    reg [3:0] m_bits;
    reg m_scl_low;
    reg m_sda_low;
    reg m_is_addr;
    reg m_addr_ack;
    reg m_have_data;
    wire gc_read;

    reg [3:0] s_state;
    reg [3:0] s_cnt;
    reg [7:0] s_shift;
    reg s_sda_low;
    reg s_stretch;
    reg s_load;
    reg s_acked;
    wire [6:0] s_rx_addr;
    wire s_addr_ok;
    wire s_match;
    wire s_gc;

    // Reset is released through two flops so every flop leaves reset together.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    twf_sync u_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .din({scl_in, sda_in}),
        .dout(line)
    );
    assign scl_hi = line[1];
    assign sda_hi = line[0];

    twf_cond u_cond (
        .clk(sys_clk),
        .rst_n(rst_n),
        .scl(scl_hi),
        .sda(sda_hi),
        .start_p(start_p),
        .stop_p(stop_p),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .busy(busy)
    );

    // General call with read direction would make several slaves contend.
    assign gc_read = (cmd_data[7:1] == `TWF_GC_ADDR) && cmd_data[0];

    // Master sequencer. Bit timing waits on the sampled SCL level, so a
    // stretching slave delays the high phase without shortening it.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_state <= M_IDLE;
            m_step <= 2'h0;
            m_cnt <= {`TWF_CNT_W{1'b0}};
            m_shift <= 9'h1FF;
            m_bits <= 4'h0;
            m_scl_low <= 1'b0;
            m_sda_low <= 1'b0;
            m_is_addr <= 1'b0;
            m_addr_ack <= 1'b0;
            m_have_data <= 1'b0;
            cmd_ready <= 1'b1;
            m_done <= 1'b0;
            m_err <= 1'b0;
            m_ack <= 1'b0;
            m_rd_data <= 8'h00;
        end else begin
            m_done <= 1'b0;
            m_err <= 1'b0;
            if (m_cnt != {`TWF_CNT_W{1'b0}}) begin
                m_cnt <= m_cnt - 1'b1;
            end
            case (m_state)
                M_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        if (cmd_code != `TWF_CMD_START || busy || gc_read) begin
                            m_err <= 1'b1;
                        end else begin
                            m_shift <= {cmd_data, 1'b1};
                            m_is_addr <= 1'b1;
                            m_step <= 2'h0;
                            m_cnt <= HALF;
                            cmd_ready <= 1'b0;
                            m_state <= M_STA;
                        end
                    end
                end
                M_WAIT: begin
                    if (cmd_valid && cmd_ready) begin
                        case (cmd_code)
                            `TWF_CMD_START: begin
                                if (gc_read) begin
                                    m_err <= 1'b1;
                                end else begin
                                    m_shift <= {cmd_data, 1'b1};
                                    m_is_addr <= 1'b1;
                                    m_step <= 2'h0;
                                    m_cnt <= HALF;
                                    cmd_ready <= 1'b0;
                                    m_state <= M_STA;
                                end
                            end
                            `TWF_CMD_WRITE: begin
                                if (!m_addr_ack) begin
                                    m_err <= 1'b1;
                                end else begin
                                    m_shift <= {cmd_data, 1'b1};
                                    m_is_addr <= 1'b0;
                                    m_have_data <= 1'b1;
                                    m_bits <= `TWF_PKT_BITS;
                                    m_cnt <= HALF;
                                    cmd_ready <= 1'b0;
                                    m_state <= M_LOW;
                                end
                            end
                            `TWF_CMD_READ: begin
                                if (!m_addr_ack) begin
                                    m_err <= 1'b1;
                                end else begin
                                    // Master as receiver drives the acknowledge bit.
                                    m_shift <= {`TWF_RD_IDLE, cmd_nack};
                                    m_is_addr <= 1'b0;
                                    m_have_data <= 1'b1;
                                    m_bits <= `TWF_PKT_BITS;
                                    m_cnt <= HALF;
                                    cmd_ready <= 1'b0;
                                    m_state <= M_LOW;
                                end
                            end
                            default: begin
                                if (m_addr_ack && !m_have_data) begin
                                    m_err <= 1'b1;
                                end else begin
                                    m_step <= 2'h0;
                                    m_cnt <= HALF;
                                    cmd_ready <= 1'b0;
                                    m_state <= M_STP;
                                end
                            end
                        endcase
                    end
                end
                M_STA: begin
                    case (m_step)
                        2'h0: begin
                            m_sda_low <= 1'b0;
                            if (m_cnt == {`TWF_CNT_W{1'b0}}) begin
                                m_scl_low <= 1'b0;
                                m_cnt <= HALF;
                                m_step <= 2'h1;
                            end
                        end
                        2'h1: begin
                            if (!scl_hi) begin
                                m_cnt <= HALF;
                            end else if (m_cnt == {`TWF_CNT_W{1'b0}}) begin
                                m_sda_low <= 1'b1;
                                m_cnt <= HALF;
                                m_step <= 2'h2;
                            end
                        end
                        default: begin
                            if (m_cnt == {`TWF_CNT_W{1'b0}}) begin
                                m_scl_low <= 1'b1;
                                m_cnt <= HALF;
                                m_bits <= `TWF_PKT_BITS;
                                m_state <= M_LOW;
                            end
                        end
                    endcase
                end
                M_LOW: begin
                    // Data bits move SDA only here, with SCL held low; M_STA and M_STP move it for START and STOP.
                    m_sda_low <= ~m_shift[8];
                    if (m_cnt == {`TWF_CNT_W{1'b0}}) begin
                        m_scl_low <= 1'b0;
                        m_cnt <= HALF;
                        m_state <= M_HIGH;
                    end
                end
                M_HIGH: begin
                    if (!scl_hi) begin
                        m_cnt <= HALF;
                    end else if (m_cnt == {`TWF_CNT_W{1'b0}}) begin
                        m_shift <= {m_shift[7:0], sda_hi};
                        m_scl_low <= 1'b1;
                        m_cnt <= HALF;
                        m_bits <= m_bits - 1'b1;
                        m_state <= (m_bits == 4'h1) ? M_FIN : M_LOW;
                    end
                end
                M_FIN: begin
                    // Ninth bit low means the receiver acknowledged.
                    m_done <= 1'b1;
                    m_ack <= ~m_shift[0];
                    m_rd_data <= m_shift[8:1];
                    if (m_is_addr) begin
                        m_addr_ack <= ~m_shift[0];
                        m_have_data <= 1'b0;
                    end
                    cmd_ready <= 1'b1;
                    m_state <= M_WAIT;
                end
                M_STP: begin
                    case (m_step)
                        2'h0: begin
                            m_sda_low <= 1'b1;
                            if (m_cnt == {`TWF_CNT_W{1'b0}}) begin
                                m_scl_low <= 1'b0;
                                m_cnt <= HALF;
                                m_step <= 2'h1;
                            end
                        end
                        2'h1: begin
                            if (!scl_hi) begin
                                m_cnt <= HALF;
                            end else if (m_cnt == {`TWF_CNT_W{1'b0}}) begin
                                m_sda_low <= 1'b0;
                                m_cnt <= HALF;
                                m_step <= 2'h2;
                            end
                        end
                        default: begin
                            if (m_cnt == {`TWF_CNT_W{1'b0}}) begin
                                m_done <= 1'b1;
                                m_addr_ack <= 1'b0;
                                m_have_data <= 1'b0;
                                cmd_ready <= 1'b1;
                                m_state <= M_IDLE;
                            end
                        end
                    endcase
                end
                default: begin
                    m_state <= M_IDLE;
                    cmd_ready <= 1'b1;
                end
            endcase
        end
    end

    // Own address must be neither general call nor in the reserved group.
    assign s_rx_addr = s_shift[7:1];
    assign s_addr_ok = (sl_addr != `TWF_GC_ADDR) && (sl_addr[6:3] != `TWF_RSV_HI);
    assign s_match = sl_en && s_addr_ok && (s_rx_addr == sl_addr);
    assign s_gc = sl_gc_en && (s_rx_addr == `TWF_GC_ADDR) && !s_shift[0];

    // Slave responder, clocked by sys_clk and stepped by sampled bus edges.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_state <= S_IDLE;
            s_cnt <= 4'h0;
            s_shift <= 8'h00;
            s_sda_low <= 1'b0;
            s_stretch <= 1'b0;
            s_load <= 1'b0;
            s_acked <= 1'b0;
            sl_addr_hit <= 1'b0;
            sl_gc_hit <= 1'b0;
            sl_rw <= 1'b0;
            sl_rx_valid <= 1'b0;
            sl_rx_data <= 8'h00;
            sl_tx_take <= 1'b0;
            sl_nack_seen <= 1'b0;
        end else begin
            sl_addr_hit <= 1'b0;
            sl_gc_hit <= 1'b0;
            sl_rx_valid <= 1'b0;
            sl_tx_take <= 1'b0;
            sl_nack_seen <= 1'b0;
            if (start_p) begin
                s_state <= S_ADDR;
                s_cnt <= 4'h0;
                s_sda_low <= 1'b0;
                s_stretch <= 1'b0;
            end else if (stop_p) begin
                s_state <= S_IDLE;
                s_sda_low <= 1'b0;
                s_stretch <= 1'b0;
            end else begin
                case (s_state)
                    S_ADDR, S_RX: begin
                        if (scl_rise && s_cnt < `TWF_BYTE_BITS) begin
                            s_shift <= {s_shift[6:0], sda_hi};
                            s_cnt <= s_cnt + 1'b1;
                        end else if (scl_fall && s_cnt == `TWF_BYTE_BITS) begin
                            s_cnt <= `TWF_PKT_BITS;
                            if (s_state == S_ADDR) begin
                                s_acked <= (s_match || s_gc) && sl_ready;
                                s_sda_low <= (s_match || s_gc) && sl_ready;
                                sl_addr_hit <= s_match;
                                sl_gc_hit <= s_gc;
                                sl_rw <= s_shift[0];
                            end else begin
                                sl_rx_valid <= 1'b1;
                                sl_rx_data <= s_shift;
                                s_acked <= sl_ready;
                                s_sda_low <= sl_ready;
                            end
                        end else if (scl_fall && s_cnt == `TWF_PKT_BITS) begin
                            s_sda_low <= 1'b0;
                            s_cnt <= 4'h0;
                            if (!s_acked) begin
                                s_state <= S_IDLE;
                            end else if (s_state == S_ADDR && sl_rw) begin
                                s_load <= 1'b1;
                                s_state <= S_TX;
                            end else begin
                                s_state <= S_RX;
                            end
                        end
                    end
                    S_TX: begin
                        if (s_load) begin
                            // Holding SCL low is the only way to wait for data.
                            if (sl_tx_valid) begin
                                s_shift <= sl_tx_data;
                                s_sda_low <= ~sl_tx_data[7];
                                sl_tx_take <= 1'b1;
                                s_load <= 1'b0;
                                s_cnt <= 4'h0;
                            end else begin
                                s_stretch <= 1'b1;
                            end
                        end else if (s_stretch) begin
                            // SCL is let go a cycle after SDA moved, so the bit is set up first.
                            s_stretch <= 1'b0;
                        end else if (scl_rise) begin
                            s_cnt <= s_cnt + 1'b1;
                            if (s_cnt == `TWF_BYTE_BITS && sda_hi) begin
                                sl_nack_seen <= 1'b1;
                                s_state <= S_IDLE;
                            end
                        end else if (scl_fall) begin
                            if (s_cnt < `TWF_BYTE_BITS) begin
                                s_shift <= {s_shift[6:0], 1'b0};
                                s_sda_low <= ~s_shift[6];
                            end else if (s_cnt == `TWF_BYTE_BITS) begin
                                s_sda_low <= 1'b0;
                            end else begin
                                s_load <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        s_sda_low <= 1'b0;
                        s_stretch <= 1'b0;
                        s_load <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Pins only ever pull low; the out values stay at zero.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            bus_busy <= 1'b0;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= m_scl_low || s_stretch;
            sda_oe <= m_sda_low || s_sda_low;
            bus_busy <= busy;
            start_seen <= start_p;
            stop_seen <= stop_p;
        end
    end
endmodule

// >>> rtl/twf_defs.vh
// Shared constants for the two-wire framing block.
`ifndef TWF_DEFS_VH
`define TWF_DEFS_VH
`define TWF_CLK_NS 5
`define TWF_HALF_NS 1250
`define TWF_HALF_CYC (`TWF_HALF_NS / `TWF_CLK_NS)
`define TWF_CNT_W 9
`define TWF_PKT_BITS 4'h9
`define TWF_BYTE_BITS 4'h8
`define TWF_GC_ADDR 7'h00
`define TWF_RSV_HI 4'hF
`define TWF_CMD_START 2'h0
`define TWF_CMD_WRITE 2'h1
`define TWF_CMD_READ 2'h2
`define TWF_CMD_STOP 2'h3
`define TWF_RD_IDLE 8'hFF
`endif

// >>> rtl/twf_sync.v
// Two-flop synchroniser for the sampled bus lines.
`timescale 1ns/1ps
module twf_sync (
    input wire clk,
    input wire rst_n,
    input wire [1:0] din,
    output wire [1:0] dout
);
    reg [1:0] meta;
    reg [1:0] stable;
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_bit
            // Lines idle high, so reset to the released level.
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta[i] <= 1'b1;
                    stable[i] <= 1'b1;
                end else begin
                    meta[i] <= din[i];
                    stable[i] <= meta[i];
                end
            end
        end
    endgenerate
    assign dout = stable;
endmodule

// >>> rtl/twf_cond.v
// Bus condition detector: START, STOP, clock edges and busy tracking.
`timescale 1ns/1ps
module twf_cond (
    input wire clk,
    input wire rst_n,
    input wire scl,
    input wire sda,
    output reg start_p,
    output reg stop_p,
    output reg scl_rise,
    output reg scl_fall,
    output reg busy
);
    reg scl_d;
    reg sda_d;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            start_p <= 1'b0;
            stop_p <= 1'b0;
            scl_rise <= 1'b0;
            scl_fall <= 1'b0;
            busy <= 1'b0;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            start_p <= scl && scl_d && sda_d && !sda;
            stop_p <= scl && scl_d && !sda_d && sda;
            scl_rise <= scl && !scl_d;
            scl_fall <= !scl && scl_d;
            // A repeated START leaves busy set; only STOP frees the bus.
            if (scl && scl_d && sda_d && !sda) begin
                busy <= 1'b1;
            end else if (scl && scl_d && !sda_d && sda) begin
                busy <= 1'b0;
            end
        end
    end
endmodule

// >>> tb/twf_core_chk.sv
// Port-level protocol checker for the two-wire framing engine.
`timescale 1ns/1ps
module twf_core_chk (
    input wire sys_clk,
    input wire resetn,
    input wire scl_in,
    input wire sda_in,
    input wire scl_out,
    input wire sda_out,
    input wire scl_oe,
    input wire sda_oe,
    input wire cmd_valid,
    input wire cmd_ready,
    input wire m_done,
    input wire m_err,
    input wire m_ack,
    input wire bus_busy,
    input wire start_seen,
    input wire stop_seen
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    AST_PULL_ONLY: assert property (!scl_out && !sda_out)
        else $error("bus line driven high");
    AST_START_DET: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] start_seen)
        else $error("start not detected");
    AST_STOP_DET: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:5] stop_seen)
        else $error("stop not detected");
    AST_BUSY_SET: assert property (start_seen |-> ##[0:1] bus_busy)
        else $error("busy not set");
    AST_BUSY_CLR: assert property (stop_seen |-> ##[0:1] !bus_busy)
        else $error("busy not cleared");
    AST_SDA_HOLD: assert property ($changed(sda_oe) && scl_in && $past(scl_in) |-> ##[1:5] (start_seen || stop_seen))
        else $error("data moved while clock high");
    AST_TAKE: assert property (cmd_valid && cmd_ready |=> !cmd_ready or ##[0:1] m_err)
        else $error("command neither taken nor refused");
    AST_HIGH_HOLD: assert property ($rose(scl_in) |=> !scl_oe [*8])
        else $error("clock high phase cut short");
    cover property (m_done && m_ack);
    cover property (m_err);
    cover property (start_seen && bus_busy);
endmodule

// >>> tb/twf_peer.sv
// Slave on the shared bus that acknowledges its address and stretches every low phase.
`timescale 1ns/1ps
module twf_peer (
    input wire scl,
    input wire sda,
    output reg scl_oe = 1'b0,
    output reg sda_oe = 1'b0,
    output reg [7:0] rx
);
    integer n = 99;
    reg me = 1'b0;
    reg [7:0] sh;
    always @(negedge sda) if (scl) n = -1;
    always @(posedge scl) sh = {sh[6:0], sda};
    always @(negedge scl) begin
        #1;
        n = n + 1;
        if (n == 8) me = sh[7:1] == 7'h2A;
        if (n > 8 && n % 9 == 8 && me) rx = sh;
        sda_oe = me && n % 9 == 8;
        // Holding longer than a half period forces the master to wait for the line.
        scl_oe = 1'b1;
        #1500;
        scl_oe = 1'b0;
    end
endmodule

// >>> tb/twf_core_tb.sv
// Self-checking bench for the two-wire framing engine.
`timescale 1ns/1ps
module twf_core_tb;
    reg sys_clk = 1'b0;
    reg resetn = 1'b0;
    reg cmd_valid = 1'b0;
    reg [1:0] cmd_code = 2'h0;
    reg [7:0] cmd_data = 8'h00;
    reg cmd_nack = 1'b0;
    reg [31:0] seed = 32'h11;
    reg [7:0] tx = 8'h00;
    reg [7:0] b;
    reg rdy = 1'b1;
    reg tv = 1'b1;
    reg [4:0] seen = 5'h00;
    integer bad_count = 0;
    integer num_checks = 0;
    integer cyc = 0;
    wire scl_oe, sda_oe, pscl, psda, cmd_ready, m_done, m_err, m_ack, bus_busy;
    wire [7:0] m_rd_data, sl_rx_data, prx;
    wire sl_rw, hit, gch, rxv, take, nks;
    wire scl_in = !(scl_oe || pscl);
    wire sda_in = !(sda_oe || psda);
    always #2.5 sys_clk = !sys_clk;
    twf_core DUT (.sys_clk(sys_clk), .resetn(resetn), .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe),
        .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready), .m_done(m_done), .m_err(m_err),
        .m_ack(m_ack), .m_rd_data(m_rd_data), .bus_busy(bus_busy), .start_seen(), .stop_seen(),
        .sl_en(1'b1), .sl_addr(7'h33), .sl_gc_en(1'b1), .sl_ready(rdy), .sl_tx_data(tx), .sl_tx_valid(tv),
        .sl_addr_hit(hit), .sl_gc_hit(gch), .sl_rw(sl_rw), .sl_rx_valid(rxv), .sl_rx_data(sl_rx_data),
        .sl_tx_take(take), .sl_nack_seen(nks));
    twf_peer PEER (.scl(scl_in), .sda(sda_in), .scl_oe(pscl), .sda_oe(psda), .rx(prx));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task summarize;
        begin
            $display("checks=%0d mismatches=%0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // Holds the request until taken, then waits for the packet or the refusal.
    task cmd(input [1:0] c, input [7:0] d, input n, input e);
        integer k;
        begin
            cmd_valid <= 1'b1;
            cmd_code <= c;
            cmd_data <= d;
            cmd_nack <= n;
            @(posedge sys_clk);
            while (cmd_ready !== 1'b1) @(posedge sys_clk);
            cmd_valid <= 1'b0;
            k = 0;
            @(posedge sys_clk);
            while (m_done !== 1'b1 && m_err !== 1'b1 && k < 9000) begin
                @(posedge sys_clk);
                k = k + 1;
            end
            chk(m_done | m_err, 1'b1);
            chk(m_err, e);
        end
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        seen <= seen | {nks, take, rxv, gch, hit};
        if (cyc == 75000) begin
            bad_count = bad_count + 1;
            summarize;
        end
    end
    initial begin
        seed = xs(seed);
        tx <= seed[15:8];
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cmd(2'h0, 8'h54, 1'b0, 1'b0);
        chk(m_ack, 1'b1);
        cmd(2'h3, 8'h00, 1'b0, 1'b1);
        seed = xs(seed);
        b = seed[7:0];
        cmd(2'h1, b, 1'b0, 1'b0);
        chk(prx, b);
        tv <= 1'b0;
        cmd(2'h0, 8'h67, 1'b0, 1'b0);
        chk(m_ack, 1'b1);
        chk(sl_rw, 1'b1);
        // The own slave has no byte yet, so it stretches SCL well past the master's low phase.
        fork
            cmd(2'h2, 8'h00, 1'b1, 1'b0);
            begin
                repeat (600) @(posedge sys_clk);
                tv <= 1'b1;
            end
        join
        chk(m_rd_data, tx);
        chk(m_ack, 1'b0);
        cmd(2'h3, 8'h00, 1'b0, 1'b0);
        cmd(2'h0, 8'hAA, 1'b0, 1'b0);
        chk(m_ack, 1'b0);
        cmd(2'h1, 8'h00, 1'b0, 1'b1);
        cmd(2'h0, 8'h01, 1'b0, 1'b1);
        cmd(2'h0, 8'h00, 1'b0, 1'b0);
        chk(m_ack, 1'b1);
        seed = xs(seed);
        b = seed[7:0];
        cmd(2'h1, b, 1'b0, 1'b0);
        chk(sl_rx_data, b);
        cmd(2'h3, 8'h00, 1'b0, 1'b0);
        rdy <= 1'b0;
        cmd(2'h0, 8'h66, 1'b0, 1'b0);
        chk(m_ack, 1'b0);
        chk(sl_rw, 1'b0);
        cmd(2'h3, 8'h00, 1'b0, 1'b0);
        chk(seen, 5'h1F);
        summarize;
    end
endmodule
bind twf_core twf_core_chk CHK (.sys_clk(sys_clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
    .scl_out(scl_out), .sda_out(sda_out), .scl_oe(scl_oe), .sda_oe(sda_oe), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .m_done(m_done), .m_err(m_err), .m_ack(m_ack), .bus_busy(bus_busy),
    .start_seen(start_seen), .stop_seen(stop_seen));
